/* File: logic/ctpm_pkg.sv */
/*
 package for the ccd timing power mode control pair: register map of the
 device end, host command registers, field positions, reset values, timing.
 assumes one 100 MHz clock shared by both ends.
*/
package ctpm_pkg;
    // device register map, reached over the write link
    localparam logic [11:0] POWER_STATE_CONTROL_ADDR = 12'h000;
    localparam logic [11:0] DATA_FORMAT_ADDR = 12'h001;
    localparam logic [11:0] OUTPUT_CONTROL_ADDR = 12'h011;
    localparam logic [11:0] TIMING_CORE_RESTART_ADDR = 12'h014;
    localparam int LINK_ADDR_W = 12;
    localparam int LINK_DATA_W = 28;
    // power_state_control fields, and the data format gray bit
    localparam int POWER_MODE_LSB = 0;
    localparam int REF_BUF_OFF_BIT = 2;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_REF_STANDBY = 2'h1;
    localparam logic [2:0] POWER_STATE_RESET = 3'h7;
    localparam int GRAY_BIT = 2;
    // host command registers
    localparam logic [3:0] HOST_LINK_ADDR_OFS = 4'h0;
    localparam logic [3:0] HOST_LINK_DATA_OFS = 4'h4;
    localparam logic [3:0] HOST_CTRL_OFS = 4'h8;
    localparam logic [3:0] HOST_STATUS_OFS = 4'hc;
    localparam int CTRL_SYNC_EN_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;
    // clock output lanes: one, two, three, four, last, reset gate
    localparam int CCD_CLK_N = 6;
    localparam logic [5:0] CCD_CLK_PARKED = 6'h0a;
    localparam logic [5:0] CCD_CLK_FLOAT_OE_N = 6'h3f;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int LINE_CLR_CYC = 12;
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int PIX_W = 14;
    localparam int HCNT_W = 12;
    localparam int LINE_LEN = 64;
    localparam int FRAME_LINES = 8;
    localparam int SYNC_W = 4;
endpackage

/* File: logic/ctpm_link_if.sv */
/*
 link between the camera host controller and the ccd timing device:
 register writes, frame and line syncs (active low), ccd clock pins and
 pixel data. assumes both ends run on the same clock; the bench resolves
 the clock pins from their active-low enables.
*/
`timescale 1ns/1ps
interface ctpm_link_if;
    import ctpm_pkg::*;
    logic wr_en;
    logic [LINK_ADDR_W-1:0] wr_addr;
    logic [LINK_DATA_W-1:0] wr_data;
    logic frame_sync_n;
    logic line_sync_n;
    logic [CCD_CLK_N-1:0] ccd_clk;
    logic [CCD_CLK_N-1:0] ccd_clk_oe_n;
    logic [PIX_W-1:0] pix_data;
    modport dev (
        input wr_en, wr_addr, wr_data, frame_sync_n, line_sync_n,
        output ccd_clk, ccd_clk_oe_n, pix_data
    );
    modport host (
        output wr_en, wr_addr, wr_data, frame_sync_n, line_sync_n,
        input pix_data
    );
endinterface

/* File: logic/ctpm_device.sv */
/*
 device end: power state decode, clock and data output levels, timing core
 restart, horizontal counter clear and gray coding of pixel data.
 assumes the host drives writes and syncs on the same clock edge domain.
*/
// Notes on behaviour
// - line sync falls with or after frame sync
// - syncs idle during start-up register writes
// - clear horizontal counter twelve cycles after line fall
// - mode bits: normal, reference standby, total shutdown
// - standby beats output enable; shutdown beats both
// - shutdown: front end, core off; clocks float
// - standby: fixed clock levels, data low
// - leave shutdown, wait 100 us, restart core
// - reference buffer disable bit, disabled after reset
// - after clock change write restart 0 then 1
// - format bit selects gray coded pixel data
// - writing restart 1 starts the timing core
// - output enable applied at next sync fall
`timescale 1ns/1ps
module ctpm_device
    import ctpm_pkg::*;
#(
    parameter int DATA_W = PIX_W,
    parameter int CNT_W = HCNT_W
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    ctpm_link_if.dev link,
    input wire logic [DATA_W-1:0] pix_bin_i,
    output logic analog_front_end_on_o,
    output logic reference_on_o,
    output logic ref_buf_on_o,
    output logic timing_core_run_o,
    output logic clocks_enabled_o,
    output logic [CNT_W-1:0] pixel_count_o
);
    typedef struct packed {
        logic [2:0] power;
        logic gray;
        logic out_req;
        logic out_act;
        logic core_rst;
        logic frame_prev;
        logic line_prev;
        logic [3:0] clr_dly;
        logic [CNT_W-1:0] hcnt;
        logic [CCD_CLK_N-1:0] clk;
        logic [CCD_CLK_N-1:0] clk_oe_n;
        logic [DATA_W-1:0] pix;
        logic afe_on;
        logic ref_on;
        logic buf_on;
        logic core_run;
    } ctpm_dev_state_t;

    ctpm_dev_state_t st_r;
    ctpm_dev_state_t st_nxt;

    function automatic logic [DATA_W-1:0] to_gray(input logic [DATA_W-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    function automatic logic is_shutdown(input logic [2:0] p);
        is_shutdown = p[POWER_MODE_LSB+1];
    endfunction

    logic frame_fall;
    logic line_fall;
    logic [1:0] mode;
    logic phase;

    always_comb begin
        st_nxt = st_r;
        frame_fall = st_r.frame_prev && !link.frame_sync_n;
        line_fall = st_r.line_prev && !link.line_sync_n;
        st_nxt.frame_prev = link.frame_sync_n;
        st_nxt.line_prev = link.line_sync_n;

        if (link.wr_en) begin
            if (link.wr_addr == POWER_STATE_CONTROL_ADDR) begin
                st_nxt.power = link.wr_data[2:0];
            end else if (link.wr_addr == DATA_FORMAT_ADDR) begin
                st_nxt.gray = link.wr_data[GRAY_BIT];
            end else if (link.wr_addr == OUTPUT_CONTROL_ADDR) begin
                st_nxt.out_req = link.wr_data[0];
            end else if (link.wr_addr == TIMING_CORE_RESTART_ADDR) begin
                st_nxt.core_rst = link.wr_data[0];
            end
        end
        // a core left running across shutdown would miss the settle wait
        if (is_shutdown(st_nxt.power)) begin
            st_nxt.core_rst = 1'b0;
        end

        // enable change waits for a sync edge so the field is not torn
        if (frame_fall || line_fall) begin
            st_nxt.out_act = st_r.out_req;
        end

        mode = st_r.power[POWER_MODE_LSB+1:POWER_MODE_LSB];
        st_nxt.afe_on = (mode == MODE_NORMAL);
        st_nxt.ref_on = !is_shutdown(st_r.power);
        st_nxt.buf_on = !st_r.power[REF_BUF_OFF_BIT] && !is_shutdown(st_r.power);
        st_nxt.core_run = st_r.core_rst && !is_shutdown(st_r.power);

        // horizontal counter: clear is delayed from the line fall
        if (line_fall) begin
            st_nxt.clr_dly = 4'(LINE_CLR_CYC - 1);
        end else if (st_r.clr_dly != 4'h0) begin
            st_nxt.clr_dly = st_r.clr_dly - 4'h1;
        end
        if (!st_r.core_run) begin
            st_nxt.hcnt = '0;
        end else if (st_r.clr_dly == 4'h1) begin
            st_nxt.hcnt = '0;
        end else begin
            st_nxt.hcnt = st_r.hcnt + 1'b1;
        end

        phase = st_r.hcnt[0];
        if (is_shutdown(st_r.power)) begin
            st_nxt.clk = '0;
            st_nxt.clk_oe_n = CCD_CLK_FLOAT_OE_N;
            st_nxt.pix = '0;
        end else if (!st_r.out_act || mode == MODE_REF_STANDBY || !st_r.core_run) begin
            st_nxt.clk = CCD_CLK_PARKED;
            st_nxt.clk_oe_n = '0;
            st_nxt.pix = '0;
        end else begin
            st_nxt.clk = {st_r.hcnt[1:0] == 2'h0, phase, !phase, phase, !phase, phase};
            st_nxt.clk_oe_n = '0;
            st_nxt.pix = st_r.gray ? to_gray(pix_bin_i) : pix_bin_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st_r.power <= POWER_STATE_RESET;
            st_r.gray <= 1'b0;
            st_r.out_req <= 1'b0;
            st_r.out_act <= 1'b0;
            st_r.core_rst <= 1'b0;
            st_r.frame_prev <= 1'b1;
            st_r.line_prev <= 1'b1;
            st_r.clr_dly <= 4'h0;
            st_r.hcnt <= '0;
            st_r.clk <= '0;
            st_r.clk_oe_n <= CCD_CLK_FLOAT_OE_N;
            st_r.pix <= '0;
            st_r.afe_on <= 1'b0;
            st_r.ref_on <= 1'b0;
            st_r.buf_on <= 1'b0;
            st_r.core_run <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.ccd_clk = st_r.clk;
    assign link.ccd_clk_oe_n = st_r.clk_oe_n;
    assign link.pix_data = PIX_W'(st_r.pix);
    assign analog_front_end_on_o = st_r.afe_on;
    assign reference_on_o = st_r.ref_on;
    assign ref_buf_on_o = st_r.buf_on;
    assign timing_core_run_o = st_r.core_run;
    assign clocks_enabled_o = st_r.out_act;
    assign pixel_count_o = st_r.hcnt;
endmodule

/* File: logic/ctpm_host.sv */
/*
 host end: software command registers, register writes over the link,
 the leave-shutdown and clock-change restart sequence, and sync generation.
 assumes a software port with read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
module ctpm_host
    import ctpm_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int LINE_CYCLES = LINE_LEN,
    parameter int LINES = FRAME_LINES
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    ctpm_link_if.host link,
    input wire logic [3:0] sw_addr_i,
    input wire logic [31:0] sw_wdata_i,
    input wire logic sw_wr_i,
    input wire logic sw_rd_i,
    output logic [31:0] sw_rdata_o
);
    typedef enum {HS_IDLE, HS_SETTLE, HS_RST1} ctpm_hstate_t;
    typedef struct packed {
        ctpm_hstate_t fsm;
        logic [LINK_ADDR_W-1:0] tgt_addr;
        logic sync_en;
        logic [15:0] wait_cnt;
        logic wr_en;
        logic [LINK_ADDR_W-1:0] wr_addr;
        logic [LINK_DATA_W-1:0] wr_data;
        logic [15:0] lcnt;
        logic [15:0] row;
        logic frame_n;
        logic line_n;
        logic [31:0] rdata;
    } ctpm_host_state_t;

    ctpm_host_state_t st_r;
    ctpm_host_state_t st_nxt;
    logic run;

    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_en = 1'b0;
        st_nxt.rdata = '0;
        // syncs held idle while the sequence writes registers
        run = st_r.sync_en && st_r.fsm == HS_IDLE;
        case (st_r.fsm)
            HS_IDLE: begin
                if (sw_wr_i && sw_addr_i == HOST_LINK_DATA_OFS) begin
                    st_nxt.wr_en = 1'b1;
                    st_nxt.wr_addr = st_r.tgt_addr;
                    st_nxt.wr_data = sw_wdata_i[LINK_DATA_W-1:0];
                end else if (sw_wr_i && sw_addr_i == HOST_CTRL_OFS &&
                             sw_wdata_i[CTRL_RESTART_BIT]) begin
                    // normal mode with the reference buffer enabled
                    st_nxt.wr_en = 1'b1;
                    st_nxt.wr_addr = POWER_STATE_CONTROL_ADDR;
                    st_nxt.wr_data = '0;
                    st_nxt.wait_cnt = 16'(SETTLE_CYCLES - 1);
                    st_nxt.fsm = HS_SETTLE;
                end
            end
            HS_SETTLE: begin
                if (st_r.wait_cnt == 16'h0) begin
                    st_nxt.wr_en = 1'b1;
                    st_nxt.wr_addr = TIMING_CORE_RESTART_ADDR;
                    st_nxt.wr_data = '0;
                    st_nxt.fsm = HS_RST1;
                end else begin
                    st_nxt.wait_cnt = st_r.wait_cnt - 16'h1;
                end
            end
            HS_RST1: begin
                st_nxt.wr_en = 1'b1;
                st_nxt.wr_addr = TIMING_CORE_RESTART_ADDR;
                st_nxt.wr_data = LINK_DATA_W'(1);
                st_nxt.fsm = HS_IDLE;
            end
            default: begin
                st_nxt.fsm = HS_IDLE;
            end
        endcase

        if (sw_wr_i && sw_addr_i == HOST_LINK_ADDR_OFS) begin
            st_nxt.tgt_addr = sw_wdata_i[LINK_ADDR_W-1:0];
        end else if (sw_wr_i && sw_addr_i == HOST_CTRL_OFS) begin
            st_nxt.sync_en = sw_wdata_i[CTRL_SYNC_EN_BIT];
        end

        if (sw_rd_i) begin
            if (sw_addr_i == HOST_LINK_ADDR_OFS) begin
                st_nxt.rdata = 32'(st_r.tgt_addr);
            end else if (sw_addr_i == HOST_CTRL_OFS) begin
                st_nxt.rdata = 32'(st_r.sync_en);
            end else if (sw_addr_i == HOST_STATUS_OFS) begin
                st_nxt.rdata = {30'h0, run, st_r.fsm != HS_IDLE};
            end
        end

        if (!run) begin
            st_nxt.lcnt = '0;
            st_nxt.row = '0;
            st_nxt.frame_n = 1'b1;
            st_nxt.line_n = 1'b1;
        end else begin
            if (st_r.lcnt == 16'(LINE_CYCLES - 1)) begin
                st_nxt.lcnt = '0;
                st_nxt.row = (st_r.row == 16'(LINES - 1)) ? 16'h0 : st_r.row + 16'h1;
            end else begin
                st_nxt.lcnt = st_r.lcnt + 16'h1;
            end
            // both syncs fall on the same cycle at a frame start
            st_nxt.line_n = !(st_nxt.lcnt < 16'(SYNC_W));
            st_nxt.frame_n = !(st_nxt.row == 16'h0 && st_nxt.lcnt < 16'(SYNC_W));
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st_r.fsm <= HS_IDLE;
            st_r.tgt_addr <= '0;
            st_r.sync_en <= 1'b0;
            st_r.wait_cnt <= '0;
            st_r.wr_en <= 1'b0;
            st_r.wr_addr <= '0;
            st_r.wr_data <= '0;
            st_r.lcnt <= '0;
            st_r.row <= '0;
            st_r.frame_n <= 1'b1;
            st_r.line_n <= 1'b1;
            st_r.rdata <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.wr_en = st_r.wr_en;
    assign link.wr_addr = st_r.wr_addr;
    assign link.wr_data = st_r.wr_data;
    assign link.frame_sync_n = st_r.frame_n;
    assign link.line_sync_n = st_r.line_n;
    assign sw_rdata_o = st_r.rdata;
endmodule

/* File: verif/ctpm_assertions.sv */
/*
 checker for the host-to-device link of the ccd timing pair.
 assumes it is instantiated beside the link with the device status ports.
*/
`timescale 1ns/1ps
module ctpm_assertions
    import ctpm_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic wr_en,
    input wire logic [LINK_ADDR_W-1:0] wr_addr,
    input wire logic [LINK_DATA_W-1:0] wr_data,
    input wire logic frame_sync_n,
    input wire logic line_sync_n,
    input wire logic [CCD_CLK_N-1:0] ccd_clk,
    input wire logic [CCD_CLK_N-1:0] ccd_clk_oe_n,
    input wire logic [PIX_W-1:0] pix_data,
    input wire logic [PIX_W-1:0] pix_bin_i,
    input wire logic timing_core_run_o,
    input wire logic clocks_enabled_o,
    input wire logic [HCNT_W-1:0] pixel_count_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // shadow copies of the device registers, fed from the link writes
    logic [2:0] pwr_r;
    logic gray_r;
    logic oe_req_r;
    logic [15:0] gap_r;
    logic run_c;
    logic rst_one;
    assign run_c = pwr_r[1:0] == MODE_NORMAL && clocks_enabled_o && timing_core_run_o;
    assign rst_one = wr_en && wr_addr == TIMING_CORE_RESTART_ADDR && wr_data[0];
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pwr_r <= POWER_STATE_RESET;
            gray_r <= 1'b0;
            oe_req_r <= 1'b0;
            gap_r <= '0;
        end else begin
            if (wr_en && wr_addr == POWER_STATE_CONTROL_ADDR)
                pwr_r <= wr_data[2:0];
            if (wr_en && wr_addr == DATA_FORMAT_ADDR)
                gray_r <= wr_data[GRAY_BIT];
            if (wr_en && wr_addr == OUTPUT_CONTROL_ADDR)
                oe_req_r <= wr_data[0];
            // saturates so a long idle spell never wraps to a short gap
            if (wr_en && wr_addr == POWER_STATE_CONTROL_ADDR)
                gap_r <= '0;
            else if (gap_r != 16'hffff)
                gap_r <= gap_r + 16'h1;
        end
    end
    sequence s_parked;
        ccd_clk_oe_n == '0 && ccd_clk == CCD_CLK_PARKED && pix_data == '0;
    endsequence
    sequence s_line_fall;
        $fell(line_sync_n) && timing_core_run_o;
    endsequence
    property p_shutdown;
        pwr_r[1] |=> ccd_clk_oe_n == CCD_CLK_FLOAT_OE_N && pix_data == '0 && !timing_core_run_o;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown outputs wrong");
    property p_standby;
        pwr_r[1:0] == MODE_REF_STANDBY |=> s_parked;
    endproperty
    a_standby: assert property (p_standby) else $error("standby levels wrong");
    property p_oe_low;
        !pwr_r[1] && !clocks_enabled_o |=> s_parked;
    endproperty
    a_oe_low: assert property (p_oe_low) else $error("disabled levels wrong");
    property p_pix;
        run_c && $past(run_c) && $past(run_c, 2) && $past(gray_r) == $past(gray_r, 2)
        |-> pix_data == ($past(gray_r) ? $past(pix_bin_i) ^ ($past(pix_bin_i) >> 1)
        : $past(pix_bin_i));
    endproperty
    a_pix: assert property (p_pix) else $error("pixel coding wrong");
    property p_hcnt_clear;
        s_line_fall |-> ##12 (pixel_count_o == '0 || !timing_core_run_o);
    endproperty
    a_hcnt_clear: assert property (p_hcnt_clear) else $error("counter not cleared");
    property p_oe_apply;
        $fell(frame_sync_n) || $fell(line_sync_n) |=> clocks_enabled_o == $past(oe_req_r);
    endproperty
    a_oe_apply: assert property (p_oe_apply) else $error("enable not applied");
    property p_core_start;
        rst_one && pwr_r[1:0] == MODE_NORMAL |-> ##2 timing_core_run_o;
    endproperty
    a_core_start: assert property (p_core_start) else $error("core did not start");
    property p_sync_order;
        $fell(line_sync_n) |=> !$fell(frame_sync_n);
    endproperty
    a_sync_order: assert property (p_sync_order) else $error("line fell before frame");
    property p_settle;
        rst_one |-> gap_r >= SETTLE_CYCLES && $past(wr_en) && !$past(wr_data[0]);
    endproperty
    a_settle: assert property (p_settle) else $error("restart too early");
endmodule

/* File: verif/testbench.sv */
/*
 self-checking bench: host and device joined by the link interface.
 assumes the software port is the only stimulus besides the pixel input.
*/
`timescale 1ns/1ps
module testbench;
    import ctpm_pkg::*;
    localparam int SETTLE = 20;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] sw_addr_i = '0;
    logic [31:0] sw_wdata_i = '0;
    logic sw_wr_i = 1'b0;
    logic sw_rd_i = 1'b0;
    logic [31:0] sw_rdata_o;
    logic [PIX_W-1:0] pix_bin_i = '0;
    logic afe_on, ref_on, buf_on, core_run, clk_en;
    logic [HCNT_W-1:0] pix_cnt;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    ctpm_link_if ctpm_link_if_i ();
    ctpm_host #(.SETTLE_CYCLES(SETTLE)) ctpm_host_i (.core_clk_i(core_clk_i),
        .resetn_i(resetn_i), .link(ctpm_link_if_i), .sw_addr_i(sw_addr_i),
        .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
        .sw_rdata_o(sw_rdata_o));
    ctpm_device ctpm_device_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .link(ctpm_link_if_i), .pix_bin_i(pix_bin_i), .analog_front_end_on_o(afe_on),
        .reference_on_o(ref_on), .ref_buf_on_o(buf_on), .timing_core_run_o(core_run),
        .clocks_enabled_o(clk_en), .pixel_count_o(pix_cnt));
    ctpm_assertions #(.SETTLE_CYCLES(SETTLE)) ctpm_assertions_i (.core_clk_i(core_clk_i),
        .resetn_i(resetn_i), .wr_en(ctpm_link_if_i.wr_en), .wr_addr(ctpm_link_if_i.wr_addr),
        .wr_data(ctpm_link_if_i.wr_data), .frame_sync_n(ctpm_link_if_i.frame_sync_n),
        .line_sync_n(ctpm_link_if_i.line_sync_n), .ccd_clk(ctpm_link_if_i.ccd_clk),
        .ccd_clk_oe_n(ctpm_link_if_i.ccd_clk_oe_n), .pix_data(ctpm_link_if_i.pix_data),
        .pix_bin_i(pix_bin_i), .timing_core_run_o(core_run), .clocks_enabled_o(clk_en),
        .pixel_count_o(pix_cnt));
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // whole run needs a few hundred cycles; this ceiling only catches hangs
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk({31'h0, got}, {31'h0, exp}, what);
    endtask
    task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        sw_addr_i <= a;
        sw_wdata_i <= d;
        sw_wr_i <= 1'b1;
        @(posedge core_clk_i);
        sw_wr_i <= 1'b0;
    endtask
    task automatic sw_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        sw_addr_i <= a;
        sw_rd_i <= 1'b1;
        @(posedge core_clk_i);
        sw_rd_i <= 1'b0;
        #1;
        chk(sw_rdata_o, exp, "read");
    endtask
    task automatic dev_wr(input logic [11:0] a, input logic [31:0] d);
        sw_wr(HOST_LINK_ADDR_OFS, {20'h0, a});
        sw_wr(HOST_LINK_DATA_OFS, d);
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask
    task automatic pins(input logic [5:0] oe, input logic [5:0] ck, input logic [13:0] px);
        chk({26'h0, ctpm_link_if_i.ccd_clk_oe_n}, {26'h0, oe}, "clock enables");
        if (oe == 6'h00)
            chk({26'h0, ctpm_link_if_i.ccd_clk}, {26'h0, ck}, "clock levels");
        chk({18'h0, ctpm_link_if_i.pix_data}, {18'h0, px}, "pixel data");
    endtask
    task automatic wait_line_fall();
        logic prev;
        int n;
        prev = ctpm_link_if_i.line_sync_n;
        for (n = 0; n < 200; n++) begin
            @(posedge core_clk_i);
            #1;
            if (prev === 1'b1 && ctpm_link_if_i.line_sync_n === 1'b0)
                break;
            prev = ctpm_link_if_i.line_sync_n;
        end
        chk1(n < 200, 1'b1, "line sync missing");
    endtask
    task automatic t_reset();
        #1;
        pins(6'h3f, 6'h00, '0);
        chk1(buf_on, 1'b0, "buffer");
        chk1(core_run, 1'b0, "core");
        chk1(ctpm_link_if_i.frame_sync_n & ctpm_link_if_i.line_sync_n, 1'b1, "sync");
        sw_rd(HOST_STATUS_OFS, 32'h0);
        sw_rd(4'h3, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_modes();
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            dev_wr(POWER_STATE_CONTROL_ADDR, {29'h0, m});
            chk1(afe_on, m[1:0] == 2'h0, "front end");
            chk1(ref_on, !m[1], "reference");
            chk1(buf_on, !m[2] && !m[1], "buffer");
            pins(m[1] ? 6'h3f : 6'h00, CCD_CLK_PARKED, '0);
        end
        $display("test modes done");
    endtask
    task automatic t_restart();
        sw_wr(HOST_CTRL_OFS, 32'h2);
        sw_rd(HOST_STATUS_OFS, 32'h1);
        repeat (5) @(posedge core_clk_i);
        #1;
        chk1(core_run, 1'b0, "core early");
        repeat (SETTLE) @(posedge core_clk_i);
        sw_rd(HOST_STATUS_OFS, 32'h0);
        chk1(core_run, 1'b1, "core run");
        chk1(afe_on, 1'b1, "front end");
        chk1(buf_on, 1'b1, "buffer");
        $display("test restart done");
    endtask
    task automatic t_enable();
        dev_wr(OUTPUT_CONTROL_ADDR, 32'h1);
        chk1(clk_en, 1'b0, "enable early");
        pins(6'h00, CCD_CLK_PARKED, '0);
        sw_wr(HOST_CTRL_OFS, 32'h1);
        wait_line_fall();
        chk1(ctpm_link_if_i.frame_sync_n, 1'b0, "frame with line");
        chk1(clk_en, 1'b0, "enable too soon");
        @(posedge core_clk_i);
        #1;
        chk1(clk_en, 1'b1, "enable applied");
        repeat (11) @(posedge core_clk_i);
        #1;
        chk({20'h0, pix_cnt}, 32'h0, "counter clear");
        chk({26'h0, ctpm_link_if_i.ccd_clk_oe_n}, 32'h0, "clocks driven");
        sw_rd(HOST_STATUS_OFS, 32'h2);
        sw_rd(HOST_CTRL_OFS, 32'h1);
        sw_rd(HOST_LINK_ADDR_OFS, {20'h0, OUTPUT_CONTROL_ADDR});
        $display("test enable done");
    endtask
    task automatic t_gray();
        logic [13:0] v;
        for (int i = 1; i >= 0; i--) begin
            dev_wr(DATA_FORMAT_ADDR, i ? 32'h4 : 32'h0);
            v = i ? 14'h2a5c : 14'h3fff;
            @(posedge core_clk_i);
            pix_bin_i <= v;
            repeat (3) @(posedge core_clk_i);
            #1;
            chk({18'h0, ctpm_link_if_i.pix_data}, {18'h0, i ? v ^ (v >> 1) : v}, "pix");
        end
        $display("test gray done");
    endtask
    task automatic t_prio();
        dev_wr(POWER_STATE_CONTROL_ADDR, {30'h0, MODE_REF_STANDBY});
        pins(6'h00, CCD_CLK_PARKED, '0);
        chk1(core_run, 1'b1, "core in standby");
        dev_wr(POWER_STATE_CONTROL_ADDR, 32'h0);
        dev_wr(OUTPUT_CONTROL_ADDR, 32'h0);
        wait_line_fall();
        repeat (2) @(posedge core_clk_i);
        #1;
        chk1(clk_en, 1'b0, "enable off");
        pins(6'h00, CCD_CLK_PARKED, '0);
        chk1(core_run, 1'b1, "core kept");
        dev_wr(OUTPUT_CONTROL_ADDR, 32'h1);
        wait_line_fall();
        dev_wr(POWER_STATE_CONTROL_ADDR, 32'h2);
        pins(6'h3f, 6'h00, '0);
        chk1(core_run, 1'b0, "core off");
        $display("test priority done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_modes();
        t_restart();
        t_enable();
        t_gray();
        t_prio();
        t_restart();
        stop_test();
    end
endmodule
